/* File: phyt_pkg.sv */
/*
 * Constants, derived cycle counts and types for the 10/100 transceiver
 * MII/RMII timing and fast-link-pulse block.
 * Assumes a single system clock clk_sys at 125 MHz (8 ns).
 */
// Summary of operation
// - transmit clock 400 ns at 10 Mb/s, 40 ns at 100 Mb/s, halves equal; the code gives 24 ns high, 16 ns low at 100 Mb/s.
// - receive clock 400 ns at 10 Mb/s, 40 ns at 100 Mb/s, 50% duty; the code gives 24 ns high, 16 ns low at 100 Mb/s.
// - carrier sense rises 600 ns (10) or 72 ns (100) after transmit enable.
// - carrier sense falls 1.0 us (10) or 72 ns (100) after transmit enable drops.
// - receive valid and nibbles follow carrier sense by 7.2 us or 170 ns.
// - receive valid, nibble and error launched from receive clock rising edge.
// - RMII with 25 MHz reference: device outputs a 50 MHz 20 ns clock.
// - RMII with 50 MHz crystal input: transfers follow that 20 ns clock.
// - link pulse bursts repeat every 16 ms, within 8 to 24 ms.
// - each pulse lasts about 100 ns; a burst spans about 2 ms.
// - clock pulses inside a burst are 128 us apart, 111 to 139 us.
// - a data pulse follows its clock pulse by 64 us, 55.5 to 69.5 us.
// - a burst holds between 17 and 33 pulses in all.
package phyt_pkg;

   // ****************************************
   // time base
   // ****************************************
   localparam int CLK_NS    = 8;
   localparam int NS_PER_US = 1000;
   localparam int NS_PER_MS = 1000000;
   localparam int SYNC_CYC  = 2;

   // ****************************************
   // clock periods, ns
   // ****************************************
   localparam int PER_W      = 10;
   localparam int PER10_NS   = 400;
   localparam int PER100_NS  = 40;
   localparam int RMII_NS    = 20;

   // ****************************************
   // carrier sense and receive latencies
   // ****************************************
   localparam int CRS_ON10_NS   = 600;
   localparam int CRS_ON100_NS  = 72;
   localparam int CRS_OFF10_NS  = 1000;
   localparam int CRS_OFF100_NS = 72;
   localparam int RLAT10_NS     = 7200;
   localparam int RLAT100_NS    = 170;

   // ****************************************
   // fast link pulse timing
   // ****************************************
   localparam int FLP_PW_NS     = 100;
   localparam int FLP_CTC_US    = 128;
   localparam int FLP_CTD_US    = 64;
   localparam int FLP_BTB_MS    = 16;
   localparam int FLP_CODE_BITS = 16;

   // typical figures round down, never below one cycle
   function automatic int phyt_cyc(input int ns);
      return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
   endfunction

   localparam int LAT_W          = 10;
   localparam int CRS_ON10_CYC   = phyt_cyc(CRS_ON10_NS);
   localparam int CRS_ON100_CYC  = phyt_cyc(CRS_ON100_NS);
   localparam int CRS_OFF10_CYC  = phyt_cyc(CRS_OFF10_NS);
   localparam int CRS_OFF100_CYC = phyt_cyc(CRS_OFF100_NS);
   localparam int RLAT10_CYC     = phyt_cyc(RLAT10_NS);
   localparam int RLAT100_CYC    = phyt_cyc(RLAT100_NS);
   localparam int FLP_PW_CYC     = phyt_cyc(FLP_PW_NS);
   localparam int FLP_CTC_CYC    = phyt_cyc(FLP_CTC_US * NS_PER_US);
   localparam int FLP_CTD_CYC    = phyt_cyc(FLP_CTD_US * NS_PER_US);
   localparam int FLP_BTB_CYC    = phyt_cyc(FLP_BTB_MS * NS_PER_MS);

   typedef enum {FLP_OFF, FLP_BURST, FLP_GAP} phyt_flp_t;
   typedef enum {RX_IDLE, RX_WAIT, RX_DATA} phyt_rx_t;

endpackage

/* File: phyt_clk_if.sv */
/*
 * Bundle between the top and one clock generator: requested period,
 * generated level and a one-cycle pulse marking its rising edge.
 * Assumes both ends run on clk_sys.
 */
interface phyt_clk_if;
   logic [phyt_pkg::PER_W-1:0] periodNs;
   logic                       level;
   logic                       rise;

   modport gen  (input periodNs, output level, output rise);
   modport user (output periodNs, input level, input rise);
endinterface

/* File: phyt_clk_gen.sv */
/*
 * Phase-accumulator clock generator; average period equals periodNs.
 * Assumes clk_sys at CLK_NS and a period of at least two system cycles.
 */
module phyt_clk_gen (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic reset_n,
   // generated clock
   phyt_clk_if.gen   clkIf
);
   import phyt_pkg::*;

   logic [PER_W-1:0] acc_reg;
   logic [PER_W-1:0] acc_next;
   logic             lvl_next;
   logic             rise_next;

   // half-period split
   // fractional periods alternate cycle counts rather than drifting
   always_comb begin
      acc_next = acc_reg + PER_W'(CLK_NS);
      if (acc_next >= clkIf.periodNs) begin
         acc_next = acc_next - clkIf.periodNs;
      end
      if (acc_next >= clkIf.periodNs) begin
         acc_next = '0;
      end
      lvl_next  = acc_next < (clkIf.periodNs >> 1);
      rise_next = lvl_next & ~clkIf.level;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         acc_reg     <= '0;
         clkIf.level <= 1'b0;
         clkIf.rise  <= 1'b0;
      end else begin
         acc_reg     <= acc_next;
         clkIf.level <= lvl_next;
         clkIf.rise  <= rise_next;
      end
   end

endmodule // phyt_clk_gen

/* File: phyt_top.sv */
/*
 * MII/RMII host-side timing and fast-link-pulse generator of a 10/100
 * transceiver. Assumes MAC pins and straps are asynchronous to clk_sys;
 * line-side receive signals and negotiation inputs come from clk_sys logic.
 */
module phyt_top #(
   parameter int FLP_CTC = phyt_pkg::FLP_CTC_CYC,
   parameter int FLP_CTD = phyt_pkg::FLP_CTD_CYC,
   parameter int FLP_BTB = phyt_pkg::FLP_BTB_CYC
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   // straps and reference pin
   input  wire logic       speed100Pin,
   input  wire logic       rmiiModePin,
   input  wire logic       ref50SelPin,
   input  wire logic       crystal_input,
   // MAC transmit
   input  wire logic       txEnPin,
   input  wire logic [3:0] txNibblePin,
   output logic            txClk,
   output logic            crs,
   // MAC receive
   output logic            rxClk,
   output logic            rxDv,
   output logic [3:0]      rxNibble,
   output logic            rxErr,
   output logic            refClkOut,
   // line side
   output logic            lineTxEn,
   output logic [3:0]      lineTxNibble,
   input  wire logic       lineRxActive,
   input  wire logic [3:0] lineRxNibble,
   input  wire logic       lineRxErr,
   // auto-negotiation
   input  wire logic       anegEnable,
   input  wire logic [phyt_pkg::FLP_CODE_BITS-1:0] linkCodeWord,
   output logic            flpPulse
);
   import phyt_pkg::*;

   localparam int TW   = $clog2(FLP_CTC + 1);
   localparam int GW   = $clog2(FLP_BTB + 1);
   localparam int PCW  = $clog2(FLP_PW_CYC + 1);
   localparam int SW   = $clog2(FLP_CODE_BITS + 1);
   localparam int PINS = 9;

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [PINS-1:0] meta_reg;
   logic [PINS-1:0] sync_reg;
   logic [PINS-1:0] sync_next;
   logic            xiPrev_reg;
   logic            speed100;
   logic            rmiiMode;
   logic            ref50Sel;
   logic            xiSync;
   logic            txEnS;
   logic [3:0]      txNibS;

   always_comb begin
      sync_next = meta_reg;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         meta_reg   <= '0;
         sync_reg   <= '0;
         xiPrev_reg <= 1'b0;
      end else begin
         meta_reg   <= {speed100Pin, rmiiModePin, ref50SelPin, crystal_input,
                        txEnPin, txNibblePin};
         sync_reg   <= sync_next;
         xiPrev_reg <= xiSync;
      end
   end

   assign {speed100, rmiiMode, ref50Sel, xiSync, txEnS, txNibS} = sync_reg;

   // ****************************************
   // clock generators
   // ****************************************
   phyt_clk_if txIf ();
   phyt_clk_if rxIf ();
   phyt_clk_if refIf ();

   always_comb begin
      txIf.periodNs  = speed100 ? PER_W'(PER100_NS) : PER_W'(PER10_NS);
      rxIf.periodNs  = speed100 ? PER_W'(PER100_NS) : PER_W'(PER10_NS);
      refIf.periodNs = PER_W'(RMII_NS);
   end

   phyt_clk_gen u_txClk  (.clk_sys(clk_sys), .reset_n(reset_n), .clkIf(txIf));
   phyt_clk_gen u_rxClk  (.clk_sys(clk_sys), .reset_n(reset_n), .clkIf(rxIf));
   phyt_clk_gen u_refClk (.clk_sys(clk_sys), .reset_n(reset_n), .clkIf(refIf));

   logic rmiiTick;
   logic txTick;
   logic rxTick;

   assign rmiiTick = ref50Sel ? (xiSync & ~xiPrev_reg) : refIf.rise;
   assign txTick   = rmiiMode ? rmiiTick : txIf.rise;
   assign rxTick   = rmiiMode ? rmiiTick : rxIf.rise;

   // ****************************************
   // transmit path and carrier sense
   // ****************************************
   logic             txClk_next;
   logic             rxClk_next;
   logic             refClk_next;
   logic             lineTxEn_next;
   logic [3:0]       lineTxNib_next;
   logic             txCrs_reg;
   logic             txCrs_next;
   logic [LAT_W-1:0] crsCnt_reg;
   logic [LAT_W-1:0] crsCnt_next;
   logic [LAT_W-1:0] crsLimit;
   logic             crs_next;

   always_comb begin
      txClk_next     = txIf.level;
      rxClk_next     = rxIf.level;
      // reference output only in 25 MHz RMII
      refClk_next    = rmiiMode & ~ref50Sel & refIf.level;
      lineTxEn_next  = lineTxEn;
      lineTxNib_next = lineTxNibble;
      if (txTick) begin
         lineTxEn_next  = txEnS;
         lineTxNib_next = txEnS ? txNibS : 4'h0;
      end
      if (txEnS) begin
         crsLimit = speed100 ? LAT_W'(CRS_ON100_CYC - SYNC_CYC - 2)
                             : LAT_W'(CRS_ON10_CYC - SYNC_CYC - 2);
      end else begin
         crsLimit = speed100 ? LAT_W'(CRS_OFF100_CYC - SYNC_CYC - 2)
                             : LAT_W'(CRS_OFF10_CYC - SYNC_CYC - 2);
      end
      txCrs_next  = txCrs_reg;
      crsCnt_next = '0;
      if (txEnS != txCrs_reg) begin
         if (crsCnt_reg >= crsLimit) begin
            txCrs_next = txEnS;
         end else begin
            crsCnt_next = crsCnt_reg + LAT_W'(1);
         end
      end
      crs_next = txCrs_next | lineRxActive;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         txClk        <= 1'b0;
         rxClk        <= 1'b0;
         refClkOut    <= 1'b0;
         lineTxEn     <= 1'b0;
         lineTxNibble <= 4'h0;
         txCrs_reg    <= 1'b0;
         crsCnt_reg   <= '0;
         crs          <= 1'b0;
      end else begin
         txClk        <= txClk_next;
         rxClk        <= rxClk_next;
         refClkOut    <= refClk_next;
         lineTxEn     <= lineTxEn_next;
         lineTxNibble <= lineTxNib_next;
         txCrs_reg    <= txCrs_next;
         crsCnt_reg   <= crsCnt_next;
         crs          <= crs_next;
      end
   end

   // ****************************************
   // receive path
   // ****************************************
   // no buffering: nibbles arriving during the latency wait are dropped
   phyt_rx_t         rxState_reg;
   phyt_rx_t         rxState_next;
   logic [LAT_W-1:0] rlat_reg;
   logic [LAT_W-1:0] rlat_next;
   logic             rxDv_next;
   logic [3:0]       rxNib_next;
   logic             rxErr_next;

   always_comb begin
      rxState_next = rxState_reg;
      rlat_next    = rlat_reg;
      rxDv_next    = rxDv;
      rxNib_next   = rxNibble;
      rxErr_next   = rxErr;
      case (rxState_reg)
         RX_IDLE: begin
            rlat_next = speed100 ? LAT_W'(RLAT100_CYC - 2) : LAT_W'(RLAT10_CYC - 2);
            if (lineRxActive) begin
               rxState_next = RX_WAIT;
            end
         end
         RX_WAIT: begin
            if (!lineRxActive) begin
               rxState_next = RX_IDLE;
            end else if (rlat_reg == '0) begin
               rxState_next = RX_DATA;
            end else begin
               rlat_next = rlat_reg - LAT_W'(1);
            end
         end
         RX_DATA: begin
            if (rxTick) begin
               rxDv_next  = lineRxActive;
               rxNib_next = lineRxActive ? lineRxNibble : 4'h0;
               rxErr_next = lineRxActive & lineRxErr;
               if (!lineRxActive) begin
                  rxState_next = RX_IDLE;
               end
            end
         end
         default: begin
            rxState_next = RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rxState_reg <= RX_IDLE;
         rlat_reg    <= '0;
         rxDv        <= 1'b0;
         rxNibble    <= 4'h0;
         rxErr       <= 1'b0;
      end else begin
         rxState_reg <= rxState_next;
         rlat_reg    <= rlat_next;
         rxDv        <= rxDv_next;
         rxNibble    <= rxNib_next;
         rxErr       <= rxErr_next;
      end
   end

   // ****************************************
   // fast link pulse bursts
   // ****************************************
   phyt_flp_t                flpState_reg;
   phyt_flp_t                flpState_next;
   logic [TW-1:0]            slotT_reg;
   logic [TW-1:0]            slotT_next;
   logic [GW-1:0]            gap_reg;
   logic [GW-1:0]            gap_next;
   logic [SW-1:0]            bit_reg;
   logic [SW-1:0]            bit_next;
   logic [PCW-1:0]           pw_reg;
   logic [PCW-1:0]           pw_next;
   logic [FLP_CODE_BITS-1:0] word_reg;
   logic [FLP_CODE_BITS-1:0] word_next;
   logic                     fire;
   logic                     flp_next;

   always_comb begin
      flpState_next = flpState_reg;
      slotT_next    = slotT_reg;
      gap_next      = gap_reg + GW'(1);
      bit_next      = bit_reg;
      word_next     = word_reg;
      fire          = 1'b0;
      case (flpState_reg)
         FLP_OFF: begin
            gap_next = '0;
            if (anegEnable) begin
               flpState_next = FLP_BURST;
               slotT_next    = '0;
               bit_next      = '0;
               word_next     = linkCodeWord;
            end
         end
         FLP_BURST: begin
            slotT_next = slotT_reg + TW'(1);
            if (slotT_reg == '0) begin
               fire = 1'b1;
            end
            if (slotT_reg == TW'(FLP_CTD) && bit_reg < SW'(FLP_CODE_BITS)) begin
               fire = word_reg[bit_reg[SW-2:0]];
            end
            if (slotT_reg == TW'(FLP_CTC - 1)) begin
               slotT_next = '0;
               if (bit_reg == SW'(FLP_CODE_BITS)) begin
                  flpState_next = FLP_GAP;
               end else begin
                  bit_next = bit_reg + SW'(1);
               end
            end
         end
         FLP_GAP: begin
            if (gap_reg == GW'(FLP_BTB - 1)) begin
               flpState_next = FLP_BURST;
               slotT_next    = '0;
               bit_next      = '0;
               gap_next      = '0;
               word_next     = linkCodeWord;
            end
         end
         default: begin
            flpState_next = FLP_OFF;
         end
      endcase
      if (!anegEnable) begin
         flpState_next = FLP_OFF;
      end
      pw_next  = '0;
      flp_next = 1'b0;
      if (fire) begin
         pw_next  = PCW'(FLP_PW_CYC - 1);
         flp_next = 1'b1;
      end else if (pw_reg != '0) begin
         pw_next  = pw_reg - PCW'(1);
         flp_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         flpState_reg <= FLP_OFF;
         slotT_reg    <= '0;
         gap_reg      <= '0;
         bit_reg      <= '0;
         pw_reg       <= '0;
         word_reg     <= '0;
         flpPulse     <= 1'b0;
      end else begin
         flpState_reg <= flpState_next;
         slotT_reg    <= slotT_next;
         gap_reg      <= gap_next;
         bit_reg      <= bit_next;
         pw_reg       <= pw_next;
         word_reg     <= word_next;
         flpPulse     <= flp_next;
      end
   end

endmodule // phyt_top

/* File: phyt_mac_model.sv */
/*
 * MAC-side transmit model: drives enable and nibble from its own clock.
 * Assumes the bench hands it go and nib as levels.
 */
module phyt_mac_model (
   // mac clock
   input  wire logic       macClk,
   // request from the bench
   input  wire logic       go,
   input  wire logic [3:0] nib,
   // pins toward the transceiver
   output logic            txEn,
   output logic [3:0]      txd
);
   initial begin
      txEn = 1'b0;
      txd  = 4'h0;
   end
   // change after edge
   // idle nibble flips so a stale value never passes for data
   always @(posedge macClk) begin
      txEn <= go;
      txd  <= go ? nib : ~txd;
   end
endmodule // phyt_mac_model

/* File: phyt_top_checker.sv */
/*
 * Port timing checker for phyt_top.
 * Assumes straps change only while reset_n is low.
 */
module phyt_top_checker (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       reset_n,
   // straps
   input wire logic       speed100Pin,
   input wire logic       rmiiModePin,
   input wire logic       ref50SelPin,
   // mac side
   input wire logic       txEnPin,
   input wire logic       txClk,
   input wire logic       crs,
   input wire logic       rxClk,
   input wire logic       rxDv,
   input wire logic [3:0] rxNibble,
   input wire logic       rxErr,
   input wire logic       refClkOut,
   // line side
   input wire logic       lineRxActive,
   input wire logic       flpPulse
);
   logic [2:0] upCnt_reg, upCnt_next;
   logic       ok, mii100, mii10, ref25;
   // straps need two edges through their synchronisers
   always_comb begin
      upCnt_next = (upCnt_reg == 3'h7) ? upCnt_reg : upCnt_reg + 3'h1;
      if (!reset_n) upCnt_next = 3'h0;
   end
   always_ff @(posedge clk_sys) begin
      upCnt_reg <= upCnt_next;
   end
   assign ok     = (upCnt_reg == 3'h7);
   assign mii100 = speed100Pin && !rmiiModePin;
   assign mii10  = !speed100Pin && !rmiiModePin;
   assign ref25  = rmiiModePin && !ref50SelPin;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n || !ok);

   txclk_fast_a: assert property (mii100 && $rose(txClk) |-> txClk[*3] ##1 !txClk[*2] ##1 txClk)
      else $error("txClk shape wrong at 100M");
   rxclk_slow_a: assert property (mii10 && $rose(rxClk) |-> ##25 $fell(rxClk) ##25 $rose(rxClk))
      else $error("rxClk shape wrong at 10M");
   crs_on_a: assert property (mii100 && !lineRxActive && !crs && $rose(txEnPin) ##1 txEnPin[*8]
      |-> ##[0:2] crs) else $error("crs late after enable");
   crs_off_a: assert property (mii100 && $fell(txEnPin) ##1 (!txEnPin && !lineRxActive)[*8]
      |-> ##[0:2] !crs) else $error("crs held after enable drop");
   rx_carrier_a: assert property ($rose(lineRxActive) |-> ##1 crs)
      else $error("crs missing on receive");
   rx_wait_a: assert property (mii100 && $rose(lineRxActive) && !rxDv |-> !rxDv[*8] ##1 !rxDv[*8])
      else $error("receive valid too early");
   rx_launch_a: assert property (!rmiiModePin && ($changed(rxDv) || $changed(rxNibble)
      || $changed(rxErr)) |-> rxClk && !$past(rxClk, 2)) else $error("receive launch off edge");
   rx_idle_a: assert property (!rxDv |-> rxNibble == 4'h0)
      else $error("nibble nonzero while idle");
   pulse_width_a: assert property ($rose(flpPulse) |-> flpPulse[*8] ##1 flpPulse[*4] ##1 !flpPulse)
      else $error("link pulse width wrong");
   ref_period_a: assert property (ref25 && $rose(refClkOut) |-> ##[2:3] $rose(refClkOut))
      else $error("reference clock period wrong");
   ref_quiet_a: assert property (!ref25 |-> !refClkOut)
      else $error("reference clock out of mode");
endmodule // phyt_top_checker

bind phyt_top phyt_top_checker chk_i (.clk_sys, .reset_n, .speed100Pin, .rmiiModePin,
   .ref50SelPin, .txEnPin, .txClk, .crs, .rxClk, .rxDv, .rxNibble, .rxErr, .refClkOut,
   .lineRxActive, .flpPulse);

/* File: phyt_top_bench.sv */
/*
 * Self-checking bench for phyt_top: clocks, carrier sense, receive, RMII, link pulses.
 * Assumes phyt_pkg, phyt_clk_if, the design and phyt_mac_model compile first.
 */
module phyt_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import phyt_pkg::*;
   localparam int CTC = 40;
   localparam int CTD = 20;
   localparam int BTB = 1000;
   logic clk_sys = 1'b0, reset_n = 1'b0, crystal_input = 1'b0;
   logic speed100Pin = 1'b0, rmiiModePin = 1'b0, ref50SelPin = 1'b0, anegEnable = 1'b0;
   logic lineRxActive = 1'b0, lineRxErr = 1'b0, go = 1'b0;
   logic [3:0] lineRxNibble = 4'h0, nib = 4'h0;
   logic [15:0] linkCodeWord = 16'h0000;
   logic txEnPin, txClk, crs, rxClk, rxDv, rxErr, refClkOut, lineTxEn, flpPulse, macClk;
   logic [3:0] txNibblePin, rxNibble, lineTxNibble;
   logic [2:0] clks;
   int fails = 0, checked = 0;

   always #4 clk_sys = ~clk_sys;
   // reference oscillator runs free, 160 ns period, edges on clk_sys falling edges
   always #80 crystal_input = ~crystal_input;
   assign clks = {refClkOut, rxClk, txClk};
   assign macClk = rmiiModePin ? (ref50SelPin ? crystal_input : refClkOut) : txClk;

   phyt_top #(.FLP_CTC(CTC), .FLP_CTD(CTD), .FLP_BTB(BTB)) DUT (.clk_sys, .reset_n,
      .speed100Pin, .rmiiModePin, .ref50SelPin, .crystal_input, .txEnPin, .txNibblePin,
      .txClk, .crs, .rxClk, .rxDv, .rxNibble, .rxErr, .refClkOut, .lineTxEn, .lineTxNibble,
      .lineRxActive, .lineRxNibble, .lineRxErr, .anegEnable, .linkCodeWord, .flpPulse);
   phyt_mac_model mac (.macClk, .go, .nib, .txEn(txEnPin), .txd(txNibblePin));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   task automatic tick;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic final_report;
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // straps only move while reset is held
   task automatic do_reset(input logic s, input logic m, input logic r);
      @(posedge clk_sys);
      reset_n <= 1'b0;
      speed100Pin <= s;
      rmiiModePin <= m;
      ref50SelPin <= r;
      repeat (5) tick;
      chk({crs, rxDv, flpPulse, lineTxEn, txClk, refClkOut}, 6'h00);
      @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (8) tick;
   endtask

   // cycles spanned by p periods of clks[i]
   task automatic per(input int i, input int p, output int n);
      logic q;
      int k;
      n = 0;
      q = 1'b1;
      k = 0;
      repeat (400) begin
         tick;
         if (clks[i] === 1'b1 && !q) k++;
         if (k > p) break;
         if (k > 0) n++;
         q = clks[i];
      end
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_clocks(input logic s);
      int n;
      per(0, 1, n);
      chk(n, s ? 5 : 50);
      per(1, 1, n);
      chk(n, s ? 5 : 50);
   endtask

   task automatic t_tx(input logic s);
      int n, e;
      e = s ? 9 : 75;
      @(posedge clk_sys);
      nib <= 4'hB;
      go <= 1'b1;
      @(posedge txEnPin);
      n = 0;
      while (crs !== 1'b1 && n < 300) begin
         tick;
         n++;
      end
      chk(32'(n >= e - 1 && n <= e + 1), 32'h1);
      chk({lineTxEn, lineTxNibble}, 5'h1B);
      e = s ? 9 : 125;
      @(posedge clk_sys);
      go <= 1'b0;
      @(negedge txEnPin);
      n = 0;
      while (crs !== 1'b0 && n < 300) begin
         tick;
         n++;
      end
      chk(32'(n >= e - 1 && n <= e + 1), 32'h1);
      chk({lineTxEn, lineTxNibble}, 5'h00);
   endtask

   task automatic t_rx(input logic s);
      int n;
      @(posedge clk_sys);
      lineRxActive <= 1'b1;
      lineRxNibble <= 4'h5;
      tick;
      chk(crs, 1'b1);
      n = 1;
      while (rxDv !== 1'b1 && n < 1100) begin
         tick;
         n++;
      end
      chk(32'(n >= (s ? 19 : 898) && n <= (s ? 28 : 954)), 32'h1);
      chk({rxErr, rxNibble}, 5'h05);
      @(posedge clk_sys);
      lineRxNibble <= 4'hC;
      lineRxErr <= 1'b1;
      repeat (s ? 7 : 52) tick;
      chk({rxDv, rxErr, rxNibble}, 6'h3C);
      @(posedge clk_sys);
      lineRxActive <= 1'b0;
      lineRxErr <= 1'b0;
      lineRxNibble <= 4'h3;
      repeat (s ? 7 : 52) tick;
      chk({rxDv, rxNibble}, 5'h00);
   endtask

   task automatic t_flp(input logic [15:0] w);
      int t[$], e[$];
      logic q;
      @(posedge clk_sys);
      linkCodeWord <= w;
      anegEnable <= 1'b1;
      repeat (3) tick;
      chk(flpPulse, 1'b1);
      t = {0};
      q = 1'b1;
      for (int i = 1; i <= BTB + 10; i++) begin
         tick;
         // the first pulse rose one cycle before this loop's origin
         if (flpPulse === 1'b1 && !q) t.push_back(i + 1);
         q = flpPulse;
      end
      for (int b = 0; b < 17; b++) begin
         e.push_back(b * CTC);
         if (b < 16 && w[b]) e.push_back(b * CTC + CTD);
      end
      e.push_back(BTB);
      chk(t.size(), e.size());
      foreach (e[j]) if (j < t.size()) chk(t[j], e[j]);
      @(posedge clk_sys);
      anegEnable <= 1'b0;
      repeat (20) tick;
      chk(flpPulse, 1'b0);
   endtask

   task automatic t_rmii(input logic r);
      int n;
      if (r) begin
         chk(refClkOut, 1'b0);
      end else begin
         per(2, 2, n);
         chk(n, 5);
      end
      @(posedge clk_sys);
      nib <= r ? 4'h9 : 4'h6;
      go <= 1'b1;
      n = 0;
      while (lineTxEn !== 1'b1 && n < 80) begin
         tick;
         n++;
      end
      chk({lineTxEn, lineTxNibble}, r ? 5'h19 : 5'h16);
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (80) tick;
      chk({lineTxEn, lineTxNibble}, 5'h00);
   endtask

   // ****************************************
   // sequence and watchdog
   // ****************************************
   initial begin
      do_reset(1'b1, 1'b0, 1'b0);
      t_clocks(1'b1);
      t_tx(1'b1);
      t_rx(1'b1);
      t_flp(16'h0000);
      t_flp(16'hFFFF);
      t_flp(16'hA5C5);
      do_reset(1'b0, 1'b0, 1'b0);
      t_clocks(1'b0);
      t_tx(1'b0);
      t_rx(1'b0);
      do_reset(1'b0, 1'b1, 1'b0);
      t_rmii(1'b0);
      do_reset(1'b0, 1'b1, 1'b1);
      t_rmii(1'b1);
      final_report;
   end

   // whole run needs well under 20000 cycles
   initial begin
      #400000;
      fails++;
      final_report;
   end
endmodule // phyt_top_bench
